// *** hdl/bsfe_map.svh ***
// Constants for the bit-force-high execution block
// Summary of operation
// - The addressed data register (0 to 255) gets its selected bit (0 to 7) forced to one, all other bits kept.
// - With the bank flag clear and indexed addressing not selected, the address resolves inside the always-visible access bank, ignoring the bank register.
// - With the bank flag set, the address is combined with the bank register's bank to reach the general-purpose file.
// - With the bank flag clear, extended set on and address at most 5Fh, the operand uses indexed literal-offset addressing.
`ifndef BSFE_MAP_SVH
`define BSFE_MAP_SVH
`define BSFE_OPC_HI 15
`define BSFE_OPC_LO 12
`define BSFE_OPC_VAL 4'h8
`define BSFE_BIT_HI 11
`define BSFE_BIT_LO 9
`define BSFE_BANKSEL_BIT 8
`define BSFE_FADDR_HI 7
`define BSFE_FADDR_LO 0
`define BSFE_IDX_LIMIT 8'h5f
`define BSFE_ACC_HI_BANK 4'hf
`define BSFE_ACC_LO_BANK 4'h0
`define BSFE_PHASES 4
`endif

// *** hdl/bsfe_pkg.sv ***
// Types for the bit-force-high execution block
package bsfe_pkg;
    typedef enum logic [1:0] {
        BSFE_MODE_ACCESS,
        BSFE_MODE_BANKED,
        BSFE_MODE_INDEXED
    } bsfe_mode_t;
    typedef enum logic [2:0] {
        BSFE_ST_DECODE,
        BSFE_ST_READ,
        BSFE_ST_MODIFY,
        BSFE_ST_WRITE
    } bsfe_state_t;
endpackage

// *** hdl/bsfe_dec_if.sv ***
// Decoded instruction fields passed from decoder to executor
`timescale 1ns/1ps
`default_nettype none
interface bsfe_dec_if;
    import bsfe_pkg::*;
    logic hit;
    logic [2:0] bit_pos;
    logic [11:0] eff_addr;
    bsfe_mode_t mode;
    modport dec (output hit, output bit_pos, output eff_addr, output mode);
    modport exe (input hit, input bit_pos, input eff_addr, input mode);
endinterface
`default_nettype wire

// *** hdl/bsfe_decode.sv ***
// Combinational decoder of the bit-force-high instruction word
`timescale 1ns/1ps
`default_nettype none
`include "bsfe_map.svh"
module bsfe_decode
    import bsfe_pkg::*;
(
    input wire logic [15:0] instr_i, // Instruction word
    input wire logic [3:0] bank_i, // Bank register contents
    input wire logic [7:0] index_base_i, // Index register low byte
    input wire logic ext_en_i, // Extended instruction set on
    bsfe_dec_if.dec dec // Decoded fields
);
    logic [7:0] faddr;
    logic asel;
    logic [8:0] idx_sum;
    assign faddr = instr_i[`BSFE_FADDR_HI:`BSFE_FADDR_LO];
    assign asel = instr_i[`BSFE_BANKSEL_BIT];
    assign idx_sum = {1'b0, index_base_i} + {1'b0, faddr};
    assign dec.hit = (instr_i[`BSFE_OPC_HI:`BSFE_OPC_LO] == `BSFE_OPC_VAL);
    assign dec.bit_pos = instr_i[`BSFE_BIT_HI:`BSFE_BIT_LO];
    always_comb begin
        if (asel) begin
            dec.mode = BSFE_MODE_BANKED;
            dec.eff_addr = {bank_i, faddr};
        end else if (ext_en_i && (faddr <= `BSFE_IDX_LIMIT)) begin
            // Only the low page of the indexed window is formed here
            dec.mode = BSFE_MODE_INDEXED;
            dec.eff_addr = {4'h0, idx_sum[7:0]};
        end else begin
            dec.mode = BSFE_MODE_ACCESS;
            // Access bank: low half maps to page 0, high half to the special page
            dec.eff_addr = faddr[7] ? {`BSFE_ACC_HI_BANK, faddr}
                                    : {`BSFE_ACC_LO_BANK, faddr};
        end
    end
endmodule // bsfe_decode
`default_nettype wire

// *** hdl/bsfe_exec.sv ***
// Four-phase read-modify-write executor for the bit-force-high instruction
`timescale 1ns/1ps
`default_nettype none
`include "bsfe_map.svh"
module bsfe_exec
    import bsfe_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic core_clk_i, // Instruction clock
    input wire logic srst_i, // Synchronous reset, active high
    input wire logic ce_i, // Clock enable, freezes state when low
    input wire logic start_i, // Instruction word valid, start a cycle
    input wire logic [15:0] instr_i, // Instruction word
    input wire logic [3:0] bank_i, // Bank register contents
    input wire logic [7:0] index_base_i, // Index register low byte
    input wire logic ext_en_i, // Extended instruction set on
    input wire logic [7:0] rd_data_i, // Data file read data, sampled at the end of the read strobe cycle
    output logic [ADDR_W-1:0] addr_o, // Data file address
    output logic rd_en_o, // Data file read strobe
    output logic wr_en_o, // Data file write strobe
    output logic [7:0] wr_data_o, // Data file write data
    output logic busy_o, // Instruction cycle in progress
    output logic done_o, // Pulse at end of the write phase
    output logic [1:0] mode_o, // Addressing mode used
    output logic flags_we_o // Status flag write, never asserted
);
    // ==========================================================
    // Decode
    bsfe_dec_if dif ();
    bsfe_decode u_dec (
        .instr_i(instr_i),
        .bank_i(bank_i),
        .index_base_i(index_base_i),
        .ext_en_i(ext_en_i),
        .dec(dif)
    );

    // ==========================================================
    // Phase sequencer
    bsfe_state_t st_r, st_nxt;
    logic [2:0] bit_r, bit_nxt;
    logic [7:0] data_r, data_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic rd_en_r, rd_en_nxt, wr_en_r, wr_en_nxt, busy_r, busy_nxt, done_r, done_nxt;
    logic [1:0] mode_r, mode_nxt;

    always_comb begin
        st_nxt = st_r;
        bit_nxt = bit_r;
        data_nxt = data_r;
        addr_nxt = addr_r;
        mode_nxt = mode_r;
        rd_en_nxt = 1'b0;
        wr_en_nxt = 1'b0;
        done_nxt = 1'b0;
        busy_nxt = busy_r;
        case (st_r)
            BSFE_ST_DECODE: begin
                if (start_i && dif.hit) begin
                    bit_nxt = dif.bit_pos;
                    addr_nxt = dif.eff_addr[ADDR_W-1:0];
                    mode_nxt = 2'(dif.mode);
                    rd_en_nxt = 1'b1;
                    busy_nxt = 1'b1;
                    st_nxt = BSFE_ST_READ;
                end
            end
            BSFE_ST_READ: begin
                data_nxt = rd_data_i;
                st_nxt = BSFE_ST_MODIFY;
            end
            BSFE_ST_MODIFY: begin
                // Only the chosen bit is forced; the rest passes through
                data_nxt = data_r | (8'h01 << bit_r);
                wr_en_nxt = 1'b1;
                st_nxt = BSFE_ST_WRITE;
            end
            BSFE_ST_WRITE: begin
                done_nxt = 1'b1;
                busy_nxt = 1'b0;
                st_nxt = BSFE_ST_DECODE;
            end
            default: begin
                st_nxt = BSFE_ST_DECODE;
                busy_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            st_r <= BSFE_ST_DECODE;
            bit_r <= 3'h0;
            data_r <= 8'h00;
            addr_r <= '0;
            mode_r <= 2'h0;
            rd_en_r <= 1'b0;
            wr_en_r <= 1'b0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else if (ce_i) begin
            st_r <= st_nxt;
            bit_r <= bit_nxt;
            data_r <= data_nxt;
            addr_r <= addr_nxt;
            mode_r <= mode_nxt;
            rd_en_r <= rd_en_nxt;
            wr_en_r <= wr_en_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
        end
    end

    // Flags are never touched by this instruction
    logic flags_we_r;
    always_ff @(posedge core_clk_i) begin
        flags_we_r <= 1'b0;
    end

    assign addr_o = addr_r;
    assign rd_en_o = rd_en_r;
    assign wr_en_o = wr_en_r;
    assign wr_data_o = data_r;
    assign busy_o = busy_r;
    assign done_o = done_r;
    assign mode_o = mode_r;
    assign flags_we_o = flags_we_r;
endmodule // bsfe_exec
`default_nettype wire

// *** tb/bsfe_exec_props.sv ***
// Checker for the bit-force-high executor ports
`timescale 1ns/1ps
`default_nettype none
module bsfe_exec_chk #(
    parameter int ADDR_W = 12
) (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic start_i,
    input wire logic [15:0] instr_i,
    input wire logic [3:0] bank_i,
    input wire logic ext_en_i,
    input wire logic [7:0] rd_data_i,
    input wire logic [ADDR_W-1:0] addr_o,
    input wire logic rd_en_o,
    input wire logic wr_en_o,
    input wire logic [7:0] wr_data_o,
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic [1:0] mode_o,
    input wire logic flags_we_o
);
    // ====
    // Properties
    default clocking @(posedge core_clk_i); endclocking
    // A frozen cycle stretches every timing window, so attempts spanning one are dropped
    default disable iff (srst_i || !ce_i);
    // Idle means decode phase, so a start is taken only then
    wire logic go = ce_i && start_i && instr_i[15:12] == 4'h8 && !busy_o;
    wire logic idx = ext_en_i && instr_i[7:0] <= 8'h5f;
    rd_pulse_a: assert property (go |=> rd_en_o && busy_o)
        else $error("read strobe late");
    write_phase_a: assert property (go |-> ##3 wr_en_o)
        else $error("write strobe late");
    done_time_a: assert property (go |-> ##4 done_o && !busy_o)
        else $error("done late");
    bit_force_a: assert property (wr_en_o |->
        wr_data_o == ($past(rd_data_i, 2) | (8'h01 << $past(instr_i[11:9], 3))))
        else $error("write data wrong");
    banked_addr_a: assert property (go && instr_i[8] |=> mode_o == 2'd1 &&
        addr_o == {$past(bank_i), $past(instr_i[7:0])})
        else $error("banked address wrong");
    access_addr_a: assert property (go && !instr_i[8] && !idx |=> mode_o == 2'd0 &&
        addr_o == {{4{$past(instr_i[7])}}, $past(instr_i[7:0])})
        else $error("access address wrong");
    indexed_mode_a: assert property (go && !instr_i[8] && idx |=> mode_o == 2'd2)
        else $error("indexed mode missing");
    no_flags_a: assert property (flags_we_o == 1'b0)
        else $error("status flags written");
endmodule // bsfe_exec_chk
bind bsfe_exec bsfe_exec_chk #(.ADDR_W(ADDR_W)) i_chk (.*);
`default_nettype wire

// *** tb/test_bit_set_file_execute.sv ***
// Self-checking bench for the bit-force-high executor
`timescale 1ns/1ps
`default_nettype none
module test_bit_set_file_execute;
    logic core_clk_i, srst_i = 1, ce_i = 1, start_i = 0, ext_en_i = 0;
    logic [15:0] instr_i = 16'h0;
    logic [3:0] bank_i = 4'h0;
    logic [7:0] index_base_i = 8'h30, rd_data_i = 8'h00, wr_data_o;
    logic [11:0] addr_o;
    logic [1:0] mode_o;
    logic rd_en_o, wr_en_o, busy_o, done_o, flags_we_o;
    int miscompares = 0, checks = 0;
    bsfe_exec i_dut (.*);
    // ====
    // Shared tasks
    task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic run(input logic [15:0] ins, input logic [3:0] bk, input logic ex,
                       input logic [7:0] d, input logic [11:0] ea, input logic [1:0] em);
        @(posedge core_clk_i);
        start_i <= 1'b1;
        instr_i <= ins;
        bank_i <= bk;
        ext_en_i <= ex;
        @(posedge core_clk_i);
        start_i <= 1'b0;
        rd_data_i <= d;
        #1 chk("addr", ea, addr_o);
        chk("mode", {10'h0, em}, mode_o);
        chk("rd_en", 12'h1, {11'h0, rd_en_o});
        chk("busy", 12'h1, {11'h0, busy_o});
        repeat (2) @(posedge core_clk_i);
        #1 chk("wr_data", {4'h0, d | (8'h01 << ins[11:9])}, {4'h0, wr_data_o});
        chk("wr_en", 12'h1, {11'h0, wr_en_o});
        @(posedge core_clk_i);
        #1 chk("done", 12'h1, {11'h0, done_o});
        chk("busy", 12'h0, {11'h0, busy_o});
    endtask
    // Clock enable held low right after a start must freeze the cycle in place
    task automatic t_freeze;
        @(posedge core_clk_i);
        start_i <= 1'b1;
        instr_i <= 16'h853c;
        bank_i <= 4'h5;
        ext_en_i <= 1'b0;
        @(posedge core_clk_i);
        start_i <= 1'b0;
        ce_i <= 1'b0;
        rd_data_i <= 8'h41;
        repeat (3) @(posedge core_clk_i);
        #1 chk("rd_en", 12'h1, {11'h0, rd_en_o});
        chk("busy", 12'h1, {11'h0, busy_o});
        @(posedge core_clk_i);
        ce_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        #1 chk("wr_data", 12'h045, {4'h0, wr_data_o});
        chk("wr_en", 12'h1, {11'h0, wr_en_o});
        @(posedge core_clk_i);
        #1 chk("done", 12'h1, {11'h0, done_o});
    endtask
    // ====
    // Scenarios
    task automatic t_bits;
        for (int b = 0; b < 8; b++) begin
            run({4'h8, 3'(b), 1'b1, 8'h3c}, 4'h5, 1'b0, 8'h0a, 12'h53c, 2'd1);
        end
    endtask
    task automatic t_access;
        run(16'h8020, 4'h9, 1'b0, 8'hff, 12'h020, 2'd0);
        run(16'h8ec5, 4'h3, 1'b1, 8'h00, 12'hfc5, 2'd0);
    endtask
    task automatic t_indexed;
        run(16'h845f, 4'h6, 1'b1, 8'h00, 12'h08f, 2'd2);
        run(16'h8460, 4'h6, 1'b1, 8'h81, 12'h060, 2'd0);
    endtask
    // Another opcode held for several cycles must never start a cycle
    task automatic t_refuse;
        @(posedge core_clk_i);
        start_i <= 1'b1;
        instr_i <= 16'h945f;
        repeat (4) begin
            @(posedge core_clk_i);
            #1 chk("rd_en", 12'h0, {11'h0, rd_en_o});
        end
        @(posedge core_clk_i);
        start_i <= 1'b0;
        #1 chk("flags_we", 12'h0, {11'h0, flags_we_o});
    endtask
    initial begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end
    initial begin
        repeat (8) @(posedge core_clk_i);
        srst_i <= 1'b0;
        t_bits();
        t_access();
        t_indexed();
        t_refuse();
        t_freeze();
        stop_test();
    end
    // Whole run needs under 100 cycles; 4000 leaves ample margin
    initial begin
        #100000;
        miscompares++;
        stop_test();
    end
endmodule // test_bit_set_file_execute
`default_nettype wire
